//--- core/dfi_cmd_core.sv
// Notes on behaviour
// - F7h merges reassigns, clears them, zeroes sectors
// - New lists usable once the merge ends, before zero fill; old gone
// - Format spans LBA 0 to native max
// - Format aborts unless erase-prepare came just before
// - Format has no data transfer phase
// - ECh sends exactly one 256-word sector
// - Word 0 is 045AH or 045EH
// - Word 2 picks one of four spin-up codes
// - Words 1, 3, 6 give default geometry
// - Serial, firmware, model words hold ASCII text
// - Word 20 reads 0003H
// - Word 21 buffer size, zero when too big
// - Word 47 reads 80h over multiple count
// - Word 48 reads 4000H
// - Words 4,5,7,8,9 zero; word 22 0038H
module dfi_cmd_core (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst,
  // Command from the task file
  input  wire logic                         cmd_valid,
  input  wire dfi_pkg::dfi_cmd_s            cmd,
  output logic                              cmd_ready,
  output logic [7:0]                        command_error_flags,
  output logic [7:0]                        command_status_flags,
  output logic                              cmd_done,
  // Drive parameters
  input  wire dfi_pkg::dfi_ident_cfg_s      ident_cfg,
  input  wire logic [dfi_pkg::DFI_LBA_W-1:0] native_max_lba,
  // Identify word stream
  output logic                              id_valid,
  input  wire logic                         id_ready,
  output logic [dfi_pkg::DFI_WORD_W-1:0]    id_data,
  output logic                              id_last,
  // Zero-fill requests to the media
  output logic                              zero_valid,
  input  wire logic                         zero_ready,
  output logic [dfi_pkg::DFI_LBA_W-1:0]     zero_lba,
  // Reassignment entries from the drive firmware
  input  wire logic                         reassign_add,
  input  wire logic [dfi_pkg::DFI_LBA_W-1:0] reassign_lba,
  output logic [dfi_pkg::DFI_LIST_AW:0]     reassign_count,
  // Defect list read port
  input  wire logic [dfi_pkg::DFI_LIST_AW-1:0] defect_rd_idx,
  output logic [dfi_pkg::DFI_LBA_W-1:0]     defect_rd_lba,
  output logic [dfi_pkg::DFI_LIST_AW:0]     defect_count
);
  import dfi_pkg::*;

  typedef enum logic [2:0] {
    DFI_IDLE, DFI_MERGE_RD, DFI_MERGE_WR, DFI_ZERO, DFI_IDENT, DFI_END
  } dfi_state_e;

  dfi_state_e               state_reg;      // Command sequencer
  logic [DFI_LIST_AW:0]     rcnt_reg;       // Reassign entries held
  logic [DFI_LIST_AW:0]     dcnt_reg;       // Committed defect entries
  logic [DFI_LIST_AW:0]     dnew_reg;       // Defect entries being built
  logic [DFI_LIST_AW:0]     midx_reg;       // Merge walk index
  logic [DFI_LBA_W-1:0]     lba_reg;        // Zero-fill address
  logic [DFI_IDX_W-1:0]     widx_reg;       // Identify word index
  logic [DFI_IDX_W-1:0]     widx_next;      // Index after this cycle
  logic [DFI_WORD_W-1:0]    word_reg;       // Identify word on the bus
  logic                     prep_reg;       // Erase-prepare just done
  logic                     abort_reg;      // Command ends in abort
  logic [7:0]               status_reg;     // Status register
  logic [7:0]               error_reg;      // Error register
  logic                     done_reg;       // Completion pulse
  logic                     merge_wr;       // Defect list write enable
  logic [DFI_LBA_W-1:0]     rmem_rd_data;   // Reassign entry being moved
  logic                     idle_take;      // Command accepted now
  logic                     fmt_ok;         // Format allowed to start

  // Two list stores
  dfi_list_mem #(
    .DEPTH (DFI_LIST_DEPTH),
    .AW    (DFI_LIST_AW),
    .DW    (DFI_LBA_W)
  ) u_reassign_mem (
    .clk     (clk),
    .wr_en   (reassign_add && state_reg == DFI_IDLE &&
              rcnt_reg < (DFI_LIST_AW+1)'(DFI_LIST_DEPTH)),
    .wr_addr (rcnt_reg[DFI_LIST_AW-1:0]),
    .wr_data (reassign_lba),
    .rd_addr (midx_reg[DFI_LIST_AW-1:0]),
    .rd_data (rmem_rd_data)
  );

  dfi_list_mem #(
    .DEPTH (DFI_LIST_DEPTH),
    .AW    (DFI_LIST_AW),
    .DW    (DFI_LBA_W)
  ) u_defect_mem (
    .clk     (clk),
    .wr_en   (merge_wr),
    .wr_addr (dnew_reg[DFI_LIST_AW-1:0]),
    .wr_data (rmem_rd_data),
    .rd_addr (defect_rd_idx),
    .rd_data (defect_rd_lba)
  );

  // Builds one identify word from the drive parameters
  function automatic logic [15:0] ident_word(
    input logic [7:0]     idx,
    input dfi_ident_cfg_s c
  );
    logic [7:0] k;
    k = 8'h00;
    ident_word = DFI_ZERO_WORD;  // Reserved words read zero
    if (idx == DFI_W_CLASS) begin
      ident_word = c.incomplete ? DFI_CLASS_INCMPL
                                : DFI_CLASS_DONE;
    end else if (idx == DFI_W_CYL) begin
      ident_word = c.cylinders;
    end else if (idx == DFI_W_SPECCFG) begin
      case ({c.spinup_need, c.incomplete})
        2'b11:   ident_word = DFI_SPIN_NEED_INC;
        2'b10:   ident_word = DFI_SPIN_NEED_CMP;
        2'b01:   ident_word = DFI_SPIN_FREE_INC;
        default: ident_word = DFI_SPIN_FREE_CMP;
      endcase
    end else if (idx == DFI_W_HEADS) begin
      ident_word = {8'h00, c.heads};  // Upper byte zero
    end else if (idx == DFI_W_SPT) begin
      ident_word = DFI_SPT_FIXED;
    end else if (idx >= DFI_W_SER_LO && idx <= DFI_W_SER_HI) begin
      k = idx - DFI_W_SER_LO;  // First characters in lowest word
      ident_word = c.serial[159 - 16*k -: 16];
    end else if (idx == DFI_W_CTRL) begin
      ident_word = DFI_CTRL_TYPE;
    end else if (idx == DFI_W_BUFSZ) begin
      // Too big for the field reads as zero
      ident_word = (c.buf_blocks > DFI_BUF_FIELD_MAX) ? DFI_ZERO_WORD
                                                     : c.buf_blocks[15:0];
    end else if (idx == DFI_W_RSVD22) begin
      ident_word = DFI_RSVD22_VAL;
    end else if (idx >= DFI_W_FW_LO && idx <= DFI_W_FW_HI) begin
      k = idx - DFI_W_FW_LO;
      ident_word = c.firmware[63 - 16*k -: 16];
    end else if (idx >= DFI_W_MOD_LO && idx <= DFI_W_MOD_HI) begin
      k = idx - DFI_W_MOD_LO;
      ident_word = c.model[319 - 16*k -: 16];
    end else if (idx == DFI_W_MULT) begin
      ident_word = {DFI_MULT_HI, c.mult_max};
    end else if (idx == DFI_W_TRUST) begin
      ident_word = DFI_TRUST_VAL;
    end
  endfunction : ident_word

  // Handshakes and strobes
  assign idle_take  = (state_reg == DFI_IDLE) && cmd_valid;
  assign fmt_ok     = prep_reg;
  assign cmd_ready  = (state_reg == DFI_IDLE);
  assign merge_wr   = (state_reg == DFI_MERGE_WR) &&
                      dnew_reg < (DFI_LIST_AW+1)'(DFI_LIST_DEPTH);
  assign zero_valid = (state_reg == DFI_ZERO);  // No host data
  assign zero_lba   = lba_reg;
  assign id_valid   = (state_reg == DFI_IDENT);
  assign id_data    = word_reg;
  assign id_last    = (state_reg == DFI_IDENT) && widx_reg == DFI_LAST_WORD;
  assign command_status_flags = status_reg;
  assign command_error_flags  = error_reg;
  assign cmd_done       = done_reg;
  assign reassign_count = rcnt_reg;
  assign defect_count   = dcnt_reg;

  // Next identify index, steps on each accepted word but the last
  always_comb begin
    widx_next = widx_reg;
    if (idle_take) begin
      widx_next = '0;  // Fresh sector on each identify
    end else if (id_valid && id_ready && !id_last) begin
      widx_next = widx_reg + 8'h01;
    end
  end

  // Sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= DFI_IDLE;
    end else begin
      case (state_reg)
        DFI_IDLE: begin
          if (cmd_valid) begin
            if (cmd.opcode == DFI_OP_FORMAT_UNIT && fmt_ok) begin
              state_reg <= DFI_MERGE_RD;
            end else if (cmd.opcode == DFI_OP_IDENTIFY) begin
              state_reg <= DFI_IDENT;
            end else begin
              state_reg <= DFI_END;  // Abort or erase-prepare
            end
          end
        end
        DFI_MERGE_RD: begin
          // Empty reassign list goes straight to zero fill
          state_reg <= (midx_reg == rcnt_reg) ? DFI_ZERO : DFI_MERGE_WR;
        end
        DFI_MERGE_WR: state_reg <= DFI_MERGE_RD;
        DFI_ZERO: begin
          if (zero_ready && lba_reg == native_max_lba) begin
            state_reg <= DFI_END;  // Native max reached
          end
        end
        DFI_IDENT: begin
          if (id_ready && id_last) begin
            state_reg <= DFI_END;  // One sector only
          end
        end
        DFI_END:  state_reg <= DFI_IDLE;
        default:  state_reg <= DFI_IDLE;
      endcase
    end
  end

  // Merge walk and list bookkeeping
  always_ff @(posedge clk) begin
    if (rst) begin
      rcnt_reg <= '0;
      dcnt_reg <= '0;
      dnew_reg <= '0;
      midx_reg <= '0;
    end else begin
      if (idle_take) begin
        midx_reg <= '0;
        dnew_reg <= dcnt_reg;  // New entries follow the old ones
      end else if (state_reg == DFI_MERGE_WR) begin
        midx_reg <= midx_reg + 1'b1;
        if (merge_wr) begin
          dnew_reg <= dnew_reg + 1'b1;  // Full list drops extras
        end
      end
      if (state_reg == DFI_MERGE_RD && midx_reg == rcnt_reg) begin
        // Both lists switch at once; the old versions are gone
        rcnt_reg <= '0;
        dcnt_reg <= dnew_reg;
      end else if (reassign_add && state_reg == DFI_IDLE &&
                   rcnt_reg < (DFI_LIST_AW+1)'(DFI_LIST_DEPTH)) begin
        rcnt_reg <= rcnt_reg + 1'b1;
      end
    end
  end

  // Zero-fill address walk from LBA 0
  always_ff @(posedge clk) begin
    if (rst) begin
      lba_reg <= '0;
    end else if (idle_take) begin
      lba_reg <= '0;  // Ignores any host-set limit
    end else if (zero_valid && zero_ready) begin
      lba_reg <= lba_reg + 1'b1;
    end
  end

  // Identify word register
  always_ff @(posedge clk) begin
    if (rst) begin
      widx_reg <= '0;
      word_reg <= '0;
    end else begin
      widx_reg <= widx_next;
      word_reg <= ident_word(widx_next, ident_cfg);
    end
  end

  // Erase-prepare must be the command right before the format
  always_ff @(posedge clk) begin
    if (rst) begin
      prep_reg <= 1'b0;
    end else if (idle_take) begin
      prep_reg <= (cmd.opcode == DFI_OP_ERASE_PREP);
    end
  end

  // Abort decision held to completion
  always_ff @(posedge clk) begin
    if (rst) begin
      abort_reg <= 1'b0;
    end else if (idle_take) begin
      // Format without prepare and unknown opcodes abort
      abort_reg <= !((cmd.opcode == DFI_OP_FORMAT_UNIT && fmt_ok) ||
                     cmd.opcode == DFI_OP_IDENTIFY ||
                     cmd.opcode == DFI_OP_ERASE_PREP);
    end
  end

  // Status and error registers
  always_ff @(posedge clk) begin
    if (rst) begin
      status_reg <= DFI_STATUS_RST;
      error_reg  <= DFI_ERROR_RST;
      done_reg   <= 1'b0;
    end else begin
      done_reg <= (state_reg == DFI_END);
      if (idle_take) begin
        status_reg <= '0;
        status_reg[DFI_ST_BSY] <= 1'b1;
        error_reg  <= '0;
      end else if (state_reg == DFI_IDENT) begin
        status_reg[DFI_ST_BSY] <= 1'b0;
        status_reg[DFI_ST_DRQ] <= 1'b1;  // Data phase of identify
      end else if (state_reg == DFI_END) begin
        status_reg <= '0;
        status_reg[DFI_ST_RDY] <= 1'b1;
        status_reg[DFI_ST_DSC] <= 1'b1;
        status_reg[DFI_ST_ERR] <= abort_reg;
        error_reg[DFI_ER_ABT]  <= abort_reg;
      end
    end
  end

endmodule : dfi_cmd_core

//--- core/dfi_list_mem.sv
module dfi_list_mem #(
  parameter int DEPTH = 64,
  parameter int AW    = 6,
  parameter int DW    = 48
) (
  // Clock
  input  wire logic          clk,
  // Write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  // Read port, data one cycle after the address
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);

  logic [DW-1:0] mem [DEPTH];  // Entry storage, no reset needed

  // Write side
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered read keeps the data output off the array decode
  always_ff @(posedge clk) begin
    rd_data <= mem[rd_addr];
  end

endmodule : dfi_list_mem

//--- core/dfi_pkg.sv
package dfi_pkg;

  // Command opcodes
  localparam logic [7:0] DFI_OP_FORMAT_UNIT  = 8'hF7;
  localparam logic [7:0] DFI_OP_IDENTIFY     = 8'hEC;
  localparam logic [7:0] DFI_OP_ERASE_PREP   = 8'hF3;
  // Only feature value the host is allowed to load for the format; the core never checks the feature field
  localparam logic [7:0] DFI_FORMAT_FEATURE  = 8'h11;

  // Status register bit positions
  localparam int DFI_ST_BSY = 7;
  localparam int DFI_ST_RDY = 6;
  localparam int DFI_ST_DSC = 4;
  localparam int DFI_ST_DRQ = 3;
  localparam int DFI_ST_ERR = 0;
  // Error register bit positions
  localparam int DFI_ER_ABT = 2;

  // Reset values of the two readable registers
  localparam logic [7:0] DFI_STATUS_RST = 8'h50;
  localparam logic [7:0] DFI_ERROR_RST  = 8'h00;

  // Sizes
  localparam int DFI_LBA_W      = 48;
  localparam int DFI_LIST_DEPTH = 64;
  localparam int DFI_LIST_AW    = 6;
  localparam int DFI_WORD_W     = 16;
  localparam int DFI_IDX_W      = 8;
  localparam logic [7:0] DFI_LAST_WORD = 8'hFF;

  // Identify word numbers and fixed contents
  localparam logic [7:0] DFI_W_CLASS   = 8'h00;
  localparam logic [7:0] DFI_W_CYL     = 8'h01;
  localparam logic [7:0] DFI_W_SPECCFG = 8'h02;
  localparam logic [7:0] DFI_W_HEADS   = 8'h03;
  localparam logic [7:0] DFI_W_SPT     = 8'h06;
  localparam logic [7:0] DFI_W_SER_LO  = 8'h0A;
  localparam logic [7:0] DFI_W_SER_HI  = 8'h13;
  localparam logic [7:0] DFI_W_CTRL    = 8'h14;
  localparam logic [7:0] DFI_W_BUFSZ   = 8'h15;
  localparam logic [7:0] DFI_W_RSVD22  = 8'h16;
  localparam logic [7:0] DFI_W_FW_LO   = 8'h17;
  localparam logic [7:0] DFI_W_FW_HI   = 8'h1A;
  localparam logic [7:0] DFI_W_MOD_LO  = 8'h1B;
  localparam logic [7:0] DFI_W_MOD_HI  = 8'h2E;
  localparam logic [7:0] DFI_W_MULT    = 8'h2F;
  localparam logic [7:0] DFI_W_TRUST   = 8'h30;

  localparam logic [15:0] DFI_CLASS_DONE   = 16'h045A;
  localparam logic [15:0] DFI_CLASS_INCMPL = 16'h045E;
  localparam logic [15:0] DFI_SPIN_NEED_INC = 16'h37C8;
  localparam logic [15:0] DFI_SPIN_NEED_CMP = 16'h738C;
  localparam logic [15:0] DFI_SPIN_FREE_INC = 16'h8C73;
  localparam logic [15:0] DFI_SPIN_FREE_CMP = 16'hC837;
  localparam logic [15:0] DFI_SPT_FIXED    = 16'h003F;
  localparam logic [15:0] DFI_CTRL_TYPE    = 16'h0003;
  localparam logic [15:0] DFI_RSVD22_VAL   = 16'h0038;
  localparam logic [7:0]  DFI_MULT_HI      = 8'h80;
  localparam logic [15:0] DFI_TRUST_VAL    = 16'h4000;
  localparam logic [15:0] DFI_ZERO_WORD    = 16'h0000;
  localparam logic [31:0] DFI_BUF_FIELD_MAX = 32'h0000_FFFF;

  // Command taken from the task file
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] feature;
  } dfi_cmd_s;

  // Drive parameters that feed the identify sector
  typedef struct packed {
    logic [15:0]  cylinders;
    logic [7:0]   heads;
    logic [159:0] serial;
    logic [63:0]  firmware;
    logic [319:0] model;
    logic [31:0]  buf_blocks;
    logic [7:0]   mult_max;
    logic         spinup_need;
    logic         incomplete;
  } dfi_ident_cfg_s;

endpackage : dfi_pkg

//--- dv/dfi_cmd_core_assertions.sv
module dfi_cmd_chk (
  // Clock and reset
  input wire logic              clk,
  input wire logic              rst,
  // Command side
  input wire logic              cmd_valid,
  input wire dfi_pkg::dfi_cmd_s cmd,
  input wire logic              cmd_ready,
  input wire logic [7:0]        command_error_flags,
  input wire logic [7:0]        command_status_flags,
  input wire logic              cmd_done,
  // Identify stream
  input wire logic              id_valid,
  input wire logic              id_ready,
  input wire logic [15:0]       id_data,
  input wire logic              id_last,
  // Zero fill
  input wire logic              zero_valid,
  input wire logic              zero_ready,
  input wire logic [47:0]       zero_lba,
  input wire logic [47:0]       native_max_lba
);
  import dfi_pkg::*;
  logic       take;     // Command accepted this edge
  logic       bad_cmd;  // Command that must be refused
  logic       prep_reg; // Last taken command was the prepare
  logic [8:0] word_reg; // Identify words since the take
  assign take = cmd_valid && cmd_ready;
  // Format without a fresh prepare, or an opcode not handled here
  assign bad_cmd = (cmd.opcode == DFI_OP_FORMAT_UNIT) ? !prep_reg :
    !(cmd.opcode inside {DFI_OP_IDENTIFY, DFI_OP_ERASE_PREP});
  // Any other command in between spoils the prepare
  always_ff @(posedge clk) begin
    if (rst) prep_reg <= 1'b0;
    else if (take) prep_reg <= (cmd.opcode == DFI_OP_ERASE_PREP);
  end
  // Counts accepted words so a short or long sector shows up
  always_ff @(posedge clk) begin
    if (rst || take) word_reg <= 9'h000;
    else if (id_valid && id_ready) word_reg <= word_reg + 9'h001;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  busy_on_take_a: assert property (take && cmd.opcode != DFI_OP_IDENTIFY
    |=> command_status_flags == 8'h80) else $error("busy missing");
  abort_flags_a: assert property (take && bad_cmd |-> ##2 cmd_done &&
    command_status_flags == 8'h51 && command_error_flags == 8'h04)
    else $error("abort flags wrong");
  prep_good_a: assert property (take && cmd.opcode == DFI_OP_ERASE_PREP
    |-> ##2 cmd_done && command_status_flags == 8'h50)
    else $error("prepare did not end good");
  id_first_word_a: assert property (take && cmd.opcode == DFI_OP_IDENTIFY
    |=> id_valid && (id_data == 16'h045A || id_data == 16'h045E))
    else $error("identify word 0 wrong");
  // Flags settle one edge after the first word goes out
  id_phase_flags_a: assert property (id_valid |=>
    command_status_flags[DFI_ST_DRQ] && !command_status_flags[DFI_ST_BSY])
    else $error("identify flags wrong");
  one_sector_a: assert property (id_valid && id_last
    |-> word_reg == 9'h0FF) else $error("sector length wrong");
  sector_done_a: assert property (id_valid && id_ready && id_last
    |-> ##[1:2] cmd_done) else $error("identify not done");
  zero_no_data_a: assert property (zero_valid |-> !id_valid &&
    !command_status_flags[DFI_ST_DRQ]) else $error("format data phase");
  zero_range_a: assert property (zero_valid
    |-> zero_lba <= native_max_lba) else $error("zero past max");
  zero_start_a: assert property ($rose(zero_valid)
    |-> zero_lba == 48'h0) else $error("zero not from 0");
  zero_step_a: assert property (zero_valid && zero_ready &&
    zero_lba != native_max_lba |=> zero_valid &&
    zero_lba == $past(zero_lba) + 48'h1) else $error("zero step wrong");
  cover property (take && cmd.opcode == DFI_OP_FORMAT_UNIT && prep_reg);
  cover property (id_valid && id_ready && id_last);
  cover property (cmd_done && command_status_flags[DFI_ST_ERR]);
endmodule : dfi_cmd_chk

//--- dv/dfi_cmd_core_tb.sv
module dfi_cmd_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dfi_pkg::*;
  logic           clk = 1'b0, rst = 1'b1, slow = 1'b0, cv = 1'b0;
  dfi_cmd_s       cmd = '0;            // Opcode and feature
  dfi_ident_cfg_s cfg = '0;            // Identify source data
  logic [47:0]    max_lba = '0, ra_lba = '0, zlba, dlba;
  logic           ra_add = 1'b0, crdy, cdone, idv, idr, idl, zv, zr;
  logic [5:0]     didx = '0;           // Defect read index
  logic [15:0]    idd;                 // Identify word
  logic [7:0]     st, er;              // Status and error
  logic [6:0]     rcnt, dcnt;          // List counts
  logic [31:0]    seed = 32'h7C06;     // Random state
  int             err_count = 0, checked = 0;
  logic [47:0]    dq[$];               // Expected defect list
  dfi_cmd_core i_dfi_cmd_core (.clk(clk), .rst(rst), .cmd_valid(cv),
    .cmd(cmd), .cmd_ready(crdy), .command_error_flags(er),
    .command_status_flags(st), .cmd_done(cdone), .ident_cfg(cfg),
    .native_max_lba(max_lba), .id_valid(idv), .id_ready(idr),
    .id_data(idd), .id_last(idl), .zero_valid(zv), .zero_ready(zr),
    .zero_lba(zlba), .reassign_add(ra_add), .reassign_lba(ra_lba),
    .reassign_count(rcnt), .defect_rd_idx(didx), .defect_rd_lba(dlba),
    .defect_count(dcnt));
  dfi_host_model i_dfi_host_model (.clk(clk), .rst(rst), .slow(slow),
    .id_ready(idr), .zero_ready(zr));
  always #2.5 clk = ~clk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // Expected identify word from the drive parameters
  function automatic logic [15:0] exp_word(int n);
    case (n)
      0: return cfg.incomplete ? 16'h045E : 16'h045A;
      1: return cfg.cylinders;
      2: return cfg.spinup_need ? (cfg.incomplete ? 16'h37C8 : 16'h738C)
        : (cfg.incomplete ? 16'h8C73 : 16'hC837);
      3: return {8'h00, cfg.heads};
      6: return 16'h003F;
      20: return 16'h0003;
      21: return (cfg.buf_blocks > 32'hFFFF) ? 16'h0000 :
        cfg.buf_blocks[15:0];
      22: return 16'h0038;
      47: return {8'h80, cfg.mult_max};
      48: return 16'h4000;
      default: begin
        if (n inside {[10:19]}) return cfg.serial[159-16*(n-10) -: 16];
        if (n inside {[23:26]}) return cfg.firmware[63-16*(n-23) -: 16];
        if (n inside {[27:46]}) return cfg.model[319-16*(n-27) -: 16];
        return 16'h0000;
      end
    endcase
  endfunction : exp_word
  task automatic chk(string what, logic [47:0] exp, logic [47:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done
  // Present a command and hold it until the core takes it
  task automatic issue(logic [7:0] op, logic [7:0] feat);
    int n;
    cv = 1'b1;
    cmd = '{opcode: op, feature: feat};
    for (n = 0; n < 50 && !crdy; n++) @(negedge clk);
    if (n == 50) begin
      chk("take timeout", 1, 0);
      test_done();
    end
    @(negedge clk);
    cv = 1'b0;
  endtask : issue
  // Follow one command to its done pulse, checking each transfer
  task automatic run(output int w, output int z);
    int n;
    w = 0;
    z = 0;
    for (n = 0; n < 2000; n++) begin
      // Falling edge: outputs settled, handshake levels final
      if (cdone) break;
      if (idv && idr) begin
        chk("id word", exp_word(w), idd);
        chk("id last", w == 255, idl);
        w++;
      end
      if (zv && zr) begin
        chk("zero lba", z, zlba);
        z++;
      end
      @(negedge clk);
    end
    if (n == 2000) begin
      chk("done timeout", 1, 0);
      test_done();
    end
  endtask : run
  initial begin
    int w, z, k, j;
    logic [7:0] op;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    chk("status", 8'h50, st);
    chk("error", 8'h00, er);
    $display("reset test done");
    issue(DFI_OP_ERASE_PREP, 8'h00);
    run(w, z);
    chk("prep status", 8'h50, st);
    // Identify under every spin-up and completeness code
    for (k = 0; k < 4; k++) begin
      for (j = 0; j < 20; j++) cfg = {cfg[577:0], rnd()};
      cfg.spinup_need = k[1];
      cfg.incomplete = k[0];
      cfg.buf_blocks[31:16] = k[0] ? 16'h0002 : 16'h0000;
      slow = k[0];
      issue(DFI_OP_IDENTIFY, 8'h00);
      run(w, z);
      chk("words", 256, w);
      chk("id status", 8'h50, st);
      $display("identify test %0d done", k);
    end
    // Format with the prepare spoilt by identify, then an unknown opcode
    for (k = 0; k < 2; k++) begin
      do op = 8'(rnd());
      while (op inside {DFI_OP_FORMAT_UNIT, DFI_OP_IDENTIFY,
        DFI_OP_ERASE_PREP});
      issue(k ? op : DFI_OP_FORMAT_UNIT, DFI_FORMAT_FEATURE);
      run(w, z);
      chk("abort status", 8'h51, st);
      chk("abort error", 8'h04, er);
      chk("abort moves", 0, w + z);
      $display("abort test %0d done", k);
    end
    // Two formats, each folding fresh reassignments into the defects
    for (j = 0; j < 2; j++) begin
      for (k = 0; k < 2 + j; k++) begin
        @(negedge clk);
        ra_lba = 48'({rnd(), rnd()});
        ra_add = 1'b1;
        dq.push_back(ra_lba);
        @(negedge clk);
        ra_add = 1'b0;
      end
      chk("reassigns", 2 + j, rcnt);
      max_lba = 48'(20 + rnd() % 8);
      slow = 1'(j);
      issue(DFI_OP_ERASE_PREP, 8'h00);
      run(w, z);
      issue(DFI_OP_FORMAT_UNIT, DFI_FORMAT_FEATURE);
      run(w, z);
      chk("zeros", max_lba + 48'h1, z);
      chk("format words", 0, w);
      chk("format status", 8'h50, st);
      chk("reassigns", 0, rcnt);
      chk("defects", dq.size(), dcnt);
      for (k = 0; k < dq.size(); k++) begin
        didx = 6'(k);
        @(negedge clk);
        chk("defect", dq[k], dlba);
      end
      $display("format test %0d done", j);
    end
    test_done();
  end
endmodule : dfi_cmd_core_tb
bind dfi_cmd_core dfi_cmd_chk i_dfi_cmd_chk (.clk(clk), .rst(rst),
  .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
  .command_error_flags(command_error_flags),
  .command_status_flags(command_status_flags), .cmd_done(cmd_done),
  .id_valid(id_valid), .id_ready(id_ready), .id_data(id_data),
  .id_last(id_last), .zero_valid(zero_valid), .zero_ready(zero_ready),
  .zero_lba(zero_lba), .native_max_lba(native_max_lba));

//--- dv/dfi_host_model.sv
module dfi_host_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Stall enable, low means always ready
  input  wire logic slow,
  // Ready lines
  output logic      id_ready,
  output logic      zero_ready
);
  logic [7:0] lfsr_reg; // Own stall pattern
  // Moves just after the rising edge, so a level seen at the falling
  // edge is the one the core samples at the next rising edge
  always_ff @(posedge clk) begin
    if (rst) lfsr_reg <= 8'hA5;
    else lfsr_reg <= {lfsr_reg[6:0],
      lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
  end
  // No data path toward the drive at all
  assign id_ready   = !slow || lfsr_reg[0];
  assign zero_ready = !slow || lfsr_reg[1];
endmodule : dfi_host_model
